/* rtl/e1apm_map.svh */
`ifndef E1APM_MAP_SVH
`define E1APM_MAP_SVH
// register byte offsets
`define E1APM_A_CTRL 8'h00
`define E1APM_A_CMD 8'h04
`define E1APM_A_STAT 8'h08
`define E1APM_A_HOOK 8'h0c
`define E1APM_A_ERRC 8'h10
`define E1APM_A_HSEL 8'h14
`define E1APM_A_HD0 8'h18
`define E1APM_A_HD1 8'h1c
`define E1APM_A_HD2 8'h20
`define E1APM_A_LSEL 8'h24
`define E1APM_A_LDAT 8'h28
`define E1APM_A_LCNT 8'h2c
// command bits
`define E1APM_C_DIS 0
`define E1APM_C_EN 1
`define E1APM_C_CLR 2
`define E1APM_C_LCLR 3
`define E1APM_C_ECLR 4
// control bit and reset values
`define E1APM_CTRL_CRC4 0
`define E1APM_RST_CRC4 1'b1
`define E1APM_RST_ALM_EN 1'b1
// detection counts, limits and store sizes
`define E1APM_OOF_N 3
`define E1APM_LOS_N 255
`define E1APM_AIS_N 512
`define E1APM_PERSIST_S 2
`define E1APM_CLEAN_S 2
`define E1APM_BURST_N 320
`define E1APM_UAS_N 10
`define E1APM_LOF_S 3
`define E1APM_ERR_MAX 65000
`define E1APM_LOG_N 100
`define E1APM_HIST_N 24
`define E1APM_HR_SEC 3600
// time base
`define E1APM_CLK_NS 25
`define E1APM_SEC_NS 1000000000
`define E1APM_SEC_CYC (`E1APM_SEC_NS / `E1APM_CLK_NS)
`endif

/* rtl/e1apm_pkg.sv */
package e1apm_pkg;
  typedef enum logic [1:0] {
    E1APM_LV_NONE = 2'h0,
    E1APM_LV_L1 = 2'h1,
    E1APM_LV_L2 = 2'h2
  } e1apm_lvl_type;
  typedef enum logic [1:0] {
    E1APM_LG_L1 = 2'h1,
    E1APM_LG_L2 = 2'h2,
    E1APM_LG_CLR = 2'h3
  } e1apm_log_type;
  typedef struct packed {
    logic stb;
    logic bit_v;
    logic fstb;
    logic ferr;
    logic fok;
    logic crc;
    logic bpv;
    logic slip;
    logic ber1;
    logic ber2;
  } e1apm_rx_type;
  typedef struct packed {
    logic reframe;
    logic resync;
    logic mute;
    logic contact;
    logic svc_ind;
    logic yellow_en;
    logic line_proc;
  } e1apm_out_type;
  typedef struct packed {
    logic [11:0] es;
    logic [11:0] bs;
    logic [11:0] uas;
    logic [11:0] lofs;
    logic [11:0] slip;
  } e1apm_perf_type;
  typedef struct packed {
    logic [1:0] code;
    logic [29:0] stamp;
  } e1apm_logent_type;
endpackage : e1apm_pkg

/* rtl/e1apm_top.sv */
// How it works
// RQ1: three framing errors declare out-of-frame, reframe
// RQ2: out-of-frame mutes all receive timeslots
// RQ3: 255 zeros declare loss of signal, resync
// RQ4: loss over two seconds: level 2, mute
// RQ5: all-ones over two seconds: level 2, mute
// RQ6: level 2 clears after two clean seconds
// RQ7: bit errors level 1/2; frame faults level 2
// RQ8: disable drops contacts, lights indicator, no yellow
// RQ9: enable restores contacts, yellow, line processing
// RQ10: clear reopens contact, logs, redeclares if persisting
// RQ11: hundred-entry stamped log, erasable
// RQ12: alarm state and thirty hook bits readable
// RQ13: per-second sampling, hourly sums, 24-hour history
// RQ14: hour end copies history then zeroes
// RQ15: count CRC errors or bipolar violations
// RQ16: errored second: any error or out-of-frame
// RQ17: bursty second: errors above one, below 320
// RQ18: severe second: over 320 errors or out-of-frame
// RQ19: unavailable after ten severe, ten clean end
// RQ20: loss-of-frame after three seconds; slip seconds
// RQ21: total error count saturates, cleared by command
// RQ22: one free-running second and hour base
//
// Our own choices: the register offsets and the strobed register port.
`include "e1apm_map.svh"
module e1apm_top #(
  parameter int unsigned SEC_CYC = `E1APM_SEC_CYC,
  parameter int unsigned HR_SEC = `E1APM_HR_SEC
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  // register port
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  // framer side
  input wire e1apm_pkg::e1apm_rx_type i_rx,
  input wire logic [29:0] i_hook,
  // alarm outputs
  output e1apm_pkg::e1apm_out_type o_ctl
);
  import e1apm_pkg::*;
  localparam int SW = $clog2(SEC_CYC);
  localparam int HW = $clog2(HR_SEC);
  localparam int P = `E1APM_PERSIST_S;

  // time base
  logic [SW-1:0] sec_cnt_q;
  logic [HW-1:0] hr_cnt_q;
  logic [29:0] stamp_q;
  wire sec_tick = sec_cnt_q == SW'(SEC_CYC - 1);
  wire hr_tick = sec_tick && hr_cnt_q == HW'(HR_SEC - 1);
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      sec_cnt_q <= '0;
      hr_cnt_q <= '0;
      stamp_q <= '0;
    end else begin
      sec_cnt_q <= sec_tick ? '0 : sec_cnt_q + SW'(1); // RQ22
      if (sec_tick) begin
        hr_cnt_q <= hr_tick ? '0 : hr_cnt_q + HW'(1); // RQ22
        stamp_q <= stamp_q + 30'h1;
      end
    end
  end

  // command decode
  wire wr_cmd = i_wr && i_addr == `E1APM_A_CMD;
  wire c_dis = wr_cmd && i_wdata[`E1APM_C_DIS];
  wire c_en = wr_cmd && i_wdata[`E1APM_C_EN];
  wire c_clr = wr_cmd && i_wdata[`E1APM_C_CLR];
  wire c_lclr = wr_cmd && i_wdata[`E1APM_C_LCLR];
  wire c_eclr = wr_cmd && i_wdata[`E1APM_C_ECLR];

  // line fault detection
  logic [1:0] ferr_run_q;
  logic [7:0] zrun_q;
  logic [9:0] orun_q;
  logic oof_q, los_q;
  wire oof_set = i_rx.fstb && i_rx.ferr && ferr_run_q == 2'(`E1APM_OOF_N - 1);
  wire los_set = i_rx.stb && !i_rx.bit_v && zrun_q == 8'(`E1APM_LOS_N - 1);
  wire ais = orun_q == 10'(`E1APM_AIS_N);
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ferr_run_q <= '0;
      zrun_q <= '0;
      orun_q <= '0;
      oof_q <= 1'b0;
      los_q <= 1'b0;
    end else begin
      if (i_rx.fstb)
        ferr_run_q <= (i_rx.ferr && !oof_set) ? ferr_run_q + 2'h1 : 2'h0;
      if (i_rx.stb) begin
        zrun_q <= i_rx.bit_v ? 8'h0 : (zrun_q == 8'hff ? zrun_q : zrun_q + 8'h1);
        orun_q <= !i_rx.bit_v ? 10'h0 : (ais ? orun_q : orun_q + 10'h1);
      end
      oof_q <= oof_set || (oof_q && !i_rx.fok); // RQ1
      los_q <= los_set || (los_q && !(i_rx.stb && i_rx.bit_v)); // RQ3
    end
  end

  // per-second collection
  logic los_all_q, ais_all_q, lof_all_q, flt_seen_q, oof_seen_q, slip_seen_q;
  logic [15:0] ecnt_q;
  logic crc4_q;
  wire cnt_ev = crc4_q ? i_rx.crc : i_rx.bpv; // RQ15
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      los_all_q <= 1'b1;
      ais_all_q <= 1'b1;
      lof_all_q <= 1'b1;
      flt_seen_q <= 1'b0;
      oof_seen_q <= 1'b0;
      slip_seen_q <= 1'b0;
      ecnt_q <= '0;
    end else if (sec_tick) begin
      los_all_q <= 1'b1;
      ais_all_q <= 1'b1;
      lof_all_q <= 1'b1;
      flt_seen_q <= 1'b0;
      oof_seen_q <= 1'b0;
      slip_seen_q <= 1'b0;
      ecnt_q <= '0;
    end else begin
      los_all_q <= los_all_q && los_q;
      ais_all_q <= ais_all_q && ais;
      lof_all_q <= lof_all_q && (oof_q || los_q);
      flt_seen_q <= flt_seen_q || los_q || oof_q || ais;
      oof_seen_q <= oof_seen_q || oof_q;
      slip_seen_q <= slip_seen_q || i_rx.slip;
      if (cnt_ev && ecnt_q != 16'hffff)
        ecnt_q <= ecnt_q + 16'h1;
    end
  end

  // second-granular persistence
  logic [1:0] los_run_q, ais_run_q, clean_run_q, lof_run_q;
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      los_run_q <= '0;
      ais_run_q <= '0;
      clean_run_q <= '0;
      lof_run_q <= '0;
    end else if (sec_tick) begin
      los_run_q <= !los_all_q ? 2'h0 : (&los_run_q ? los_run_q : los_run_q + 2'h1);
      ais_run_q <= !ais_all_q ? 2'h0 : (&ais_run_q ? ais_run_q : ais_run_q + 2'h1);
      clean_run_q <= flt_seen_q ? 2'h0 : (&clean_run_q ? clean_run_q : clean_run_q + 2'h1);
      lof_run_q <= !lof_all_q ? 2'h0 : (&lof_run_q ? lof_run_q : lof_run_q + 2'h1);
    end
  end

  // alarm level
  e1apm_lvl_type lvl_q, lvl_d;
  logic alm_en_q;
  wire persist = los_run_q > 2'(P) || ais_run_q > 2'(P); // RQ4 RQ5
  wire l2_set = persist || oof_q || i_rx.ber2; // RQ7
  wire l2_ok = clean_run_q >= 2'(`E1APM_CLEAN_S) && !l2_set; // RQ6
  always_comb begin
    case (lvl_q)
      E1APM_LV_NONE: lvl_d = l2_set ? E1APM_LV_L2 : (i_rx.ber1 ? E1APM_LV_L1 : lvl_q);
      E1APM_LV_L1: lvl_d = l2_set ? E1APM_LV_L2 : (i_rx.ber1 ? lvl_q : E1APM_LV_NONE);
      E1APM_LV_L2: lvl_d = !l2_ok ? lvl_q : (i_rx.ber1 ? E1APM_LV_L1 : E1APM_LV_NONE);
      default: lvl_d = E1APM_LV_NONE;
    endcase
  end
  // a clear drops to none for one cycle; a standing cause redeclares next
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      lvl_q <= E1APM_LV_NONE;
      alm_en_q <= `E1APM_RST_ALM_EN;
      crc4_q <= `E1APM_RST_CRC4;
    end else begin
      lvl_q <= c_clr ? E1APM_LV_NONE : lvl_d; // RQ10
      if (c_dis)
        alm_en_q <= 1'b0; // RQ8
      else if (c_en)
        alm_en_q <= 1'b1; // RQ9
      if (i_wr && i_addr == `E1APM_A_CTRL)
        crc4_q <= i_wdata[`E1APM_CTRL_CRC4];
    end
  end

  // outputs
  wire alm_on = lvl_q != E1APM_LV_NONE;
  wire is_l2 = lvl_q == E1APM_LV_L2;
  e1apm_out_type ctl_d;
  assign ctl_d.reframe = oof_set; // RQ1
  assign ctl_d.resync = los_set; // RQ3
  assign ctl_d.mute = oof_q || (is_l2 && persist); // RQ2 RQ4 RQ5
  assign ctl_d.contact = alm_en_q && alm_on; // RQ8 RQ9 RQ10
  assign ctl_d.svc_ind = !alm_en_q || alm_on; // RQ8 RQ10
  assign ctl_d.yellow_en = alm_en_q && is_l2; // RQ8 RQ9
  assign ctl_d.line_proc = alm_en_q && is_l2; // RQ8 RQ9 RQ10
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst)
      o_ctl <= '0;
    else
      o_ctl <= ctl_d;
  end

  // alarm log
  e1apm_logent_type log_mem [`E1APM_LOG_N];
  logic [6:0] lptr_q, lcnt_q, lsel_q;
  wire lg_new = lvl_d != lvl_q && lvl_d != E1APM_LV_NONE && !c_clr;
  wire lg_we = c_clr || lg_new; // RQ10 RQ11
  e1apm_logent_type lg_ent;
  assign lg_ent.code = c_clr ? E1APM_LG_CLR : lvl_d;
  assign lg_ent.stamp = stamp_q;
  wire [7:0] lrd_raw = 8'(lptr_q) + 8'(`E1APM_LOG_N - 1) - 8'(lsel_q);
  wire [7:0] lrd_idx = lrd_raw >= 8'(`E1APM_LOG_N) ? lrd_raw - 8'(`E1APM_LOG_N) : lrd_raw;
  wire lsel_ok = lsel_q < lcnt_q;
  always_ff @(posedge i_mclk) begin
    if (lg_we)
      log_mem[lptr_q] <= lg_ent;
  end
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      lptr_q <= '0;
      lcnt_q <= '0;
      lsel_q <= '0;
    end else begin
      if (c_lclr) begin
        lptr_q <= '0; // RQ11
        lcnt_q <= '0; // RQ11
      end else if (lg_we) begin
        lptr_q <= lptr_q == 7'(`E1APM_LOG_N - 1) ? 7'h0 : lptr_q + 7'h1;
        if (lcnt_q != 7'(`E1APM_LOG_N))
          lcnt_q <= lcnt_q + 7'h1;
      end
      if (i_wr && i_addr == `E1APM_A_LSEL)
        lsel_q <= i_wdata[6:0];
    end
  end

  // second classification
  logic unav_q;
  logic [3:0] srun_q, okrun_q;
  wire es = ecnt_q != 16'h0 || oof_seen_q; // RQ16
  wire bs = ecnt_q > 16'h1 && ecnt_q < 16'(`E1APM_BURST_N); // RQ17
  wire ses = ecnt_q > 16'(`E1APM_BURST_N) || oof_seen_q; // RQ18
  wire enter = !unav_q && ses && srun_q == 4'(`E1APM_UAS_N - 1);
  wire leave = unav_q && !ses && okrun_q == 4'(`E1APM_UAS_N - 1);
  // clean seconds inside the unavailable span stay pending until resolved
  wire [3:0] uas_inc = enter ? 4'(`E1APM_UAS_N) :
                       (unav_q && ses) ? okrun_q + 4'h1 : 4'h0; // RQ19
  wire lofs_inc = lof_all_q && lof_run_q >= 2'(`E1APM_LOF_S - 1); // RQ20
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      unav_q <= 1'b0;
      srun_q <= '0;
      okrun_q <= '0;
    end else if (sec_tick) begin
      unav_q <= enter || (unav_q && !leave); // RQ19
      srun_q <= (ses && !unav_q && !enter) ? srun_q + 4'h1 : 4'h0;
      okrun_q <= (unav_q && !ses && !leave) ? okrun_q + 4'h1 : 4'h0;
    end
  end

  // hourly counters and history
  e1apm_perf_type cur_q, cur_d;
  e1apm_perf_type hist_mem [`E1APM_HIST_N];
  logic [4:0] hptr_q, hsel_q;
  logic [15:0] errc_q;
  assign cur_d.es = cur_q.es + 12'(es);
  assign cur_d.bs = cur_q.bs + 12'(bs);
  assign cur_d.uas = cur_q.uas + 12'(uas_inc);
  assign cur_d.lofs = cur_q.lofs + 12'(lofs_inc);
  assign cur_d.slip = cur_q.slip + 12'(slip_seen_q); // RQ20
  wire [4:0] sec_sum = 5'(es) + 5'(bs) + 5'(uas_inc) + 5'(lofs_inc) + 5'(slip_seen_q);
  wire [16:0] errc_add = 17'(errc_q) + 17'(sec_sum);
  wire sat = errc_add >= 17'(`E1APM_ERR_MAX);
  always_ff @(posedge i_mclk) begin
    if (hr_tick)
      hist_mem[hptr_q] <= cur_d; // RQ14
  end
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cur_q <= '0;
      hptr_q <= '0;
      errc_q <= '0;
    end else begin
      if (hr_tick) begin
        cur_q <= '0; // RQ13 RQ14
        hptr_q <= hptr_q == 5'(`E1APM_HIST_N - 1) ? 5'h0 : hptr_q + 5'h1;
      end else if (sec_tick)
        cur_q <= cur_d; // RQ13
      if (c_eclr)
        errc_q <= '0; // RQ21
      else if (sec_tick)
        errc_q <= sat ? 16'(`E1APM_ERR_MAX) : errc_add[15:0]; // RQ21
    end
  end

  // history select: 0 is the running hour, 1 the last full hour
  wire [5:0] hrd_raw = 6'(hptr_q) + 6'(`E1APM_HIST_N) - 6'(hsel_q);
  wire [5:0] hrd_idx = hrd_raw >= 6'(`E1APM_HIST_N) ? hrd_raw - 6'(`E1APM_HIST_N) : hrd_raw;
  wire e1apm_perf_type hv = hsel_q == 5'h0 ? cur_q : hist_mem[hrd_idx[4:0]];
  wire [4:0] hsel_in = i_wdata[4:0] > 5'(`E1APM_HIST_N) ? 5'(`E1APM_HIST_N) : i_wdata[4:0];
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst)
      hsel_q <= '0;
    else if (i_wr && i_addr == `E1APM_A_HSEL)
      hsel_q <= hsel_in;
  end

  // read mux, unmapped reads return zero
  logic [31:0] rd_mux;
  always_comb begin
    case (i_addr)
      `E1APM_A_CTRL: rd_mux = {31'h0, crc4_q};
      `E1APM_A_STAT: rd_mux = {25'h0, unav_q, ais, los_q, oof_q, alm_en_q, lvl_q}; // RQ12
      `E1APM_A_HOOK: rd_mux = {2'h0, i_hook}; // RQ12
      `E1APM_A_ERRC: rd_mux = {16'h0, errc_q};
      `E1APM_A_HSEL: rd_mux = {27'h0, hsel_q};
      `E1APM_A_HD0: rd_mux = {4'h0, hv.bs, 4'h0, hv.es};
      `E1APM_A_HD1: rd_mux = {4'h0, hv.lofs, 4'h0, hv.uas};
      `E1APM_A_HD2: rd_mux = {20'h0, hv.slip};
      `E1APM_A_LSEL: rd_mux = {25'h0, lsel_q};
      `E1APM_A_LDAT: rd_mux = lsel_ok ? log_mem[lrd_idx[6:0]] : 32'h0; // RQ11
      `E1APM_A_LCNT: rd_mux = {25'h0, lcnt_q};
      default: rd_mux = 32'h0;
    endcase
  end
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst)
      o_rdata <= '0;
    else
      o_rdata <= i_rd ? rd_mux : 32'h0;
  end

  // checks
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_sys_rst);

  property p_oof;
    oof_set |=> oof_q && o_ctl.reframe;
  endproperty
  a_oof: assert property (p_oof) else $error("oof not declared"); // RQ1

  property p_mute;
    oof_q |=> o_ctl.mute;
  endproperty
  a_mute: assert property (p_mute) else $error("oof not muted"); // RQ2

  property p_los;
    i_rx.stb && !i_rx.bit_v && zrun_q == 8'hfe |=> los_q && o_ctl.resync;
  endproperty
  a_los: assert property (p_los) else $error("los not declared"); // RQ3

  property p_l2;
    // a second edge may end the persistence, so mute is only owed away from it
    persist && !c_clr && !sec_tick |=> lvl_q == E1APM_LV_L2 ##1 o_ctl.mute;
  endproperty
  a_l2: assert property (p_l2) else $error("persist no level 2"); // RQ4

  property p_dis;
    c_dis |=> !alm_en_q ##1 !o_ctl.contact && o_ctl.svc_ind && !o_ctl.line_proc;
  endproperty
  a_dis: assert property (p_dis) else $error("disable ignored"); // RQ8

  property p_clr;
    c_clr && !c_lclr |=> lvl_q == E1APM_LV_NONE && $past(lptr_q) != lptr_q;
  endproperty
  a_clr: assert property (p_clr) else $error("clear not handled"); // RQ10

  property p_lclr;
    c_lclr |=> lcnt_q == 7'h0;
  endproperty
  a_lclr: assert property (p_lclr) else $error("log not erased"); // RQ11

  property p_hr;
    hr_tick |=> cur_q == '0 && hist_mem[$past(hptr_q)] == $past(cur_d);
  endproperty
  a_hr: assert property (p_hr) else $error("hour rollover wrong"); // RQ14

  property p_sat;
    errc_q <= 16'(`E1APM_ERR_MAX);
  endproperty
  a_sat: assert property (p_sat) else $error("error count over limit"); // RQ21
endmodule : e1apm_top

/* bench/e1apm_framer_model.sv */
module e1apm_framer_model
  import e1apm_pkg::*;
(
  // clock
  input wire logic i_mclk,
  // line side toward the monitor
  output e1apm_pkg::e1apm_rx_type o_rx
);
  timeunit 1ns;
  timeprecision 100ps;
  logic lvl1 = 1'b0;
  logic lvl2 = 1'b0;

  initial o_rx = '0;

  // n back-to-back strobes of v, then one idle cycle
  task automatic drive(input e1apm_rx_type v, input int n);
    v.ber1 = lvl1;
    v.ber2 = lvl2;
    repeat (n) begin
      @(posedge i_mclk);
      o_rx <= v;
    end
    @(posedge i_mclk);
    // line value is not held between bits: show its inverse
    o_rx <= '{bit_v: ~v.bit_v, ber1: lvl1, ber2: lvl2, default: 1'b0};
  endtask : drive

  // rate levels stay until changed, as the framer holds them
  task automatic set_ber(input logic b1, input logic b2);
    @(posedge i_mclk);
    lvl1 = b1;
    lvl2 = b2;
    o_rx.ber1 <= b1;
    o_rx.ber2 <= b2;
  endtask : set_ber
endmodule : e1apm_framer_model

/* bench/tb_top.sv */
`include "e1apm_map.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import e1apm_pkg::*;
  // short second and hour keep the run small
  localparam int SEC = 400;
  localparam int HRS = 4;
  logic i_mclk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic [29:0] hook = 30'h2345_6789;
  logic [31:0] e1;
  e1apm_rx_type rx;
  e1apm_out_type ctl;
  int error_cnt = 0;
  int comparisons = 0;
  int cyc = 0;
  int reframe_cnt = 0;
  int resync_cnt = 0;

  always #12.5 i_mclk = ~i_mclk;

  always @(posedge i_mclk) begin
    cyc <= i_sys_rst ? 0 : cyc + 1;
    reframe_cnt <= reframe_cnt + int'(ctl.reframe);
    resync_cnt <= resync_cnt + int'(ctl.resync);
  end

  e1apm_top #(.SEC_CYC(SEC), .HR_SEC(HRS)) uut (
    .i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_rx(rx), .i_hook(hook), .o_ctl(ctl)
  );
  e1apm_framer_model fr (.i_mclk(i_mclk), .o_rx(rx));

  task automatic chk(input string n, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", n, exp, got);
    end
  endtask : chk

  task automatic wc(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask : wc

  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge i_mclk);
    wr <= 1'b0;
  endtask : wreg

  task automatic rreg(input logic [7:0] a, output logic [31:0] d);
    @(posedge i_mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge i_mclk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask : rreg

  task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] m,
                      input logic [31:0] exp);
    logic [31:0] d;
    rreg(a, d);
    chk(n, exp, d & m);
  endtask : rchk

  // waits for cycle 40 of second s so burst edges never straddle a boundary
  task automatic at(input int s);
    while (cyc % (SEC * HRS) != s * SEC + 40) @(posedge i_mclk);
  endtask : at

  task automatic end_of_test;
    $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_of_test

  initial begin
    repeat (40000) @(posedge i_mclk);
    error_cnt++;
    $display("mismatch watchdog expected done seen hang");
    end_of_test;
  end

  initial begin
    repeat (10) @(posedge i_mclk);
    i_sys_rst <= 1'b0;
    wc(1);
    chk("ctl", 32'h0, {25'h0, ctl});
    rchk("ctrl", `E1APM_A_CTRL, 32'h1, 32'h1);
    rchk("stat", `E1APM_A_STAT, '1, 32'h4);
    rchk("hook", `E1APM_A_HOOK, '1, {2'h0, hook});
    rchk("unmapped", 8'h30, '1, 32'h0);
    rchk("lcnt", `E1APM_A_LCNT, '1, 32'h0);
    fr.drive('{fstb: 1'b1, ferr: 1'b1, default: 1'b0}, 2);
    fr.drive('{fstb: 1'b1, default: 1'b0}, 1);
    fr.drive('{fstb: 1'b1, ferr: 1'b1, default: 1'b0}, 2);
    wc(4);
    chk("reframe", 32'h0, reframe_cnt);
    fr.drive('{fstb: 1'b1, ferr: 1'b1, default: 1'b0}, 1);
    wc(3);
    chk("reframe", 32'h1, reframe_cnt);
    chk("mute", 32'h1, ctl.mute);
    rchk("stat", `E1APM_A_STAT, 32'hb, 32'ha);
    wreg(`E1APM_A_CMD, 32'h1 << `E1APM_C_DIS);
    wc(3);
    chk("ctl", 32'h14, {25'h0, ctl});
    rchk("stat", `E1APM_A_STAT, 32'h7, 32'h2);
    wreg(`E1APM_A_CMD, 32'h1 << `E1APM_C_EN);
    wc(3);
    chk("ctl", 32'h1f, {25'h0, ctl});
    wreg(`E1APM_A_CMD, 32'h1 << `E1APM_C_CLR);
    wc(4);
    rchk("stat", `E1APM_A_STAT, 32'h3, 32'h2);
    rchk("lcnt", `E1APM_A_LCNT, '1, 32'h3);
    wreg(`E1APM_A_LSEL, 32'h1);
    rchk("ldat", `E1APM_A_LDAT, 32'hc000_0000, 32'hc000_0000);
    wreg(`E1APM_A_LSEL, 32'h0);
    rchk("ldat", `E1APM_A_LDAT, 32'hc000_0000, 32'h8000_0000);
    fr.drive('{fok: 1'b1, default: 1'b0}, 1);
    wc(SEC);
    rchk("stat", `E1APM_A_STAT, 32'h3, 32'h2);
    wc(SEC * 5 / 2);
    rchk("stat", `E1APM_A_STAT, 32'hb, 32'h0);
    chk("ctl", 32'h0, {25'h0, ctl});
    wreg(`E1APM_A_CMD, 32'h1 << `E1APM_C_LCLR);
    rchk("lcnt", `E1APM_A_LCNT, '1, 32'h0);
    fr.set_ber(1'b1, 1'b0);
    wc(4);
    rchk("stat", `E1APM_A_STAT, 32'h3, 32'h1);
    fr.set_ber(1'b0, 1'b1);
    wc(4);
    rchk("stat", `E1APM_A_STAT, 32'h3, 32'h2);
    fr.set_ber(1'b0, 1'b0);
    wc(SEC * 7 / 2);
    rchk("stat", `E1APM_A_STAT, 32'h3, 32'h0);
    fr.drive('{stb: 1'b1, default: 1'b0}, 254);
    fr.drive('{stb: 1'b1, bit_v: 1'b1, default: 1'b0}, 1);
    wc(3);
    chk("resync", 32'h0, resync_cnt);
    fr.drive('{stb: 1'b1, default: 1'b0}, 255);
    wc(3);
    chk("resync", 32'h1, resync_cnt);
    rchk("stat", `E1APM_A_STAT, 32'h13, 32'h10);
    wc(SEC * 3 / 2);
    rchk("stat", `E1APM_A_STAT, 32'h3, 32'h0);
    wc(SEC * 3);
    rchk("stat", `E1APM_A_STAT, 32'h3, 32'h2);
    chk("mute", 32'h1, ctl.mute);
    fr.drive('{stb: 1'b1, bit_v: 1'b1, default: 1'b0}, 1);
    wc(SEC * 7 / 2);
    rchk("stat", `E1APM_A_STAT, 32'h13, 32'h0);
    fr.drive('{stb: 1'b1, default: 1'b0}, 1);
    fr.drive('{stb: 1'b1, bit_v: 1'b1, default: 1'b0}, 511);
    fr.drive('{stb: 1'b1, default: 1'b0}, 1);
    wc(3);
    rchk("stat", `E1APM_A_STAT, 32'h20, 32'h0);
    fr.drive('{stb: 1'b1, bit_v: 1'b1, default: 1'b0}, 512);
    wc(3);
    rchk("stat", `E1APM_A_STAT, 32'h20, 32'h20);
    wc(SEC * 3 / 2);
    rchk("stat", `E1APM_A_STAT, 32'h3, 32'h0);
    wc(SEC * 3);
    rchk("stat", `E1APM_A_STAT, 32'h3, 32'h2);
    fr.drive('{stb: 1'b1, default: 1'b0}, 1);
    wc(SEC * 7 / 2);
    rchk("stat", `E1APM_A_STAT, 32'h23, 32'h0);
    at(0);
    fr.drive('{crc: 1'b1, default: 1'b0}, 5);
    at(1);
    fr.drive('{bpv: 1'b1, default: 1'b0}, 5);
    at(2);
    fr.drive('{crc: 1'b1, default: 1'b0}, 321);
    at(3);
    fr.drive('{crc: 1'b1, slip: 1'b1, default: 1'b0}, 1);
    at(0);
    wreg(`E1APM_A_HSEL, 32'h1);
    rchk("hd0", `E1APM_A_HD0, '1, {4'h0, 12'h1, 4'h0, 12'h3});
    rchk("hd2", `E1APM_A_HD2, 32'hfff, 32'h1);
    rchk("hd1", `E1APM_A_HD1, '1, 32'h0);
    rreg(`E1APM_A_ERRC, e1);
    wreg(`E1APM_A_HSEL, 32'h0);
    rchk("hd0", `E1APM_A_HD0, '1, 32'h0);
    wreg(`E1APM_A_CTRL, 32'h0);
    rchk("ctrl", `E1APM_A_CTRL, '1, 32'h0);
    at(1);
    fr.drive('{bpv: 1'b1, default: 1'b0}, 3);
    fr.drive('{crc: 1'b1, default: 1'b0}, 3);
    at(0);
    wreg(`E1APM_A_HSEL, 32'h1);
    rchk("hd0", `E1APM_A_HD0, '1, {4'h0, 12'h1, 4'h0, 12'h1});
    wreg(`E1APM_A_HSEL, 32'h2);
    rchk("hd0", `E1APM_A_HD0, '1, {4'h0, 12'h1, 4'h0, 12'h3});
    rchk("errc", `E1APM_A_ERRC, '1, e1 + 32'h2);
    wreg(`E1APM_A_CMD, 32'h1 << `E1APM_C_ECLR);
    rchk("errc", `E1APM_A_ERRC, '1, 32'h0);
    end_of_test;
  end
endmodule : tb_top
